// ===== src/srch_consts.vh
// Purpose: Constants for the sensor record command handler
// Assumes: Byte-serial request/response framing at the user ports
// Notes:   Offsets are byte positions within a request or response
`ifndef SRCH_CONSTS_VH
`define SRCH_CONSTS_VH
// Command codes seen by the handler
`define SRCH_CMD_STORE_CFG     8'h01
`define SRCH_CMD_READ_CFG      8'h02
`define SRCH_CMD_SDR_INFO      8'h20
`define SRCH_CMD_SDR_GET       8'h21
`define SRCH_CMD_CAPS          8'h01
// Request byte positions of the store command
`define SRCH_REQ_ENTRY_BYTE    5'd5
`define SRCH_REQ_SENSOR_BYTE   5'd6
`define SRCH_REQ_LAST_BYTE     5'd18
// Config entry count and record layout
`define SRCH_NUM_ENTRIES       5'd18
`define SRCH_REC_BYTES         5'd13
// Completion codes
`define SRCH_CC_OK             8'h00
`define SRCH_CC_INVALID_CMD    8'hC1
`define SRCH_CC_OUT_OF_RANGE   8'hC9
`define SRCH_CC_BAD_LENGTH     8'hC7
// Capability bits returned by the query: store, read, sdr info, sdr get
`define SRCH_CAPS_VALUE        8'h0F
// Timing: response turnaround pause in ns and derived cycles at 40 MHz
`define SRCH_CLK_MHZ           40
`define SRCH_TURN_NS           100
`define SRCH_TURN_CYC          ((`SRCH_TURN_NS * `SRCH_CLK_MHZ + 999) / 1000)
`endif

// ===== src/srch_rec_mem.v
// Purpose: Storage of the sensor config entries, one byte address per field
// Assumes: Single clock, synchronous read one cycle after address
// Notes:   Contents are not cleared by reset; valid flags are kept by the caller
`timescale 1ns/10ps
`default_nettype none
module srch_rec_mem #(
  parameter ENTRIES = 18,
  parameter AW      = 9
) (
  input  wire          clk_sys,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [7:0]    rd_data
);
  // One array holds every record byte
  reg [7:0] mem_reg [0:ENTRIES*16-1];

  // Write and registered read
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end
endmodule
`default_nettype wire

// ===== src/srch_top.v
// Purpose: Command handler for sensor config entries and device records
// Assumes: Requests arrive one byte per req_valid pulse, req_last on final byte
// Notes:   Responses leave one byte per rsp_valid, completion code first
`include "srch_consts.vh"
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Store request: entry byte5, sensor byte6, fields
// - Keep device records for managed sensors
// - Record gives type, number, thresholds, events
// - Device record info reports supported commands
// - Always answer device record info, fetch
module srch_top #(
  parameter ENTRIES = 18
) (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       req_valid,
  input  wire [7:0] req_data,
  input  wire       req_last,
  input  wire [7:0] req_cmd,
  output reg        rsp_valid,
  output reg  [7:0] rsp_data,
  output reg        rsp_last,
  output reg        busy,
  output reg  [7:0] stored_count
);
  localparam ST_RX   = 2'd0;
  localparam ST_TURN = 2'd1;
  localparam ST_TX   = 2'd2;
  localparam ST_RD   = 2'd3;

  reg [1:0]  state_reg;          // Sequencer state
  reg [4:0]  idx_reg;            // Request byte position, from 1
  reg [4:0]  entry_reg;          // Selected config entry
  reg [7:0]  cc_reg;             // Completion code being built
  reg [4:0]  tx_cnt_reg;         // Response bytes remaining after code
  reg [4:0]  tx_pos_reg;         // Record byte being read
  reg [3:0]  turn_reg;           // Turnaround counter
  reg [7:0]  cmd_reg;            // Latched command
  reg [ENTRIES-1:0] valid_reg;   // Entry holds stored data
  reg        first_reg;          // Next byte sent is the code
  wire [7:0] mem_q;              // Record byte read back
  wire       mem_we;             // Record byte write strobe
  wire [8:0] wr_addr;            // Record write address
  wire [8:0] rd_addr;            // Record read address
  wire [4:0] fld;                // Field slot inside a record

  // Byte 6 onward go to record slots 0..12 in order
  assign fld     = idx_reg - `SRCH_REQ_SENSOR_BYTE;
  // A refused entry index keeps its low bits, so gate on the code too
  // field bytes stored
  assign mem_we  = (state_reg == ST_RX) && req_valid && (cmd_reg == `SRCH_CMD_STORE_CFG) &&
                   (idx_reg >= `SRCH_REQ_SENSOR_BYTE) && (idx_reg <= `SRCH_REQ_LAST_BYTE) &&
                   (entry_reg < `SRCH_NUM_ENTRIES) && (cc_reg == `SRCH_CC_OK);
  assign wr_addr = {entry_reg, fld[3:0]};
  assign rd_addr = {entry_reg, tx_pos_reg[3:0]};

  srch_rec_mem #(
    .ENTRIES (32),
    .AW      (9)
  ) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (mem_we),
    .wr_addr (wr_addr),
    .wr_data (req_data),
    .rd_addr (rd_addr),
    .rd_data (mem_q)
  );

  // Count of filled entries for status
  integer i;
  reg [7:0] cnt_next;
  always @* begin
    cnt_next = 8'h00;
    for (i = 0; i < ENTRIES; i = i + 1) begin
      cnt_next = cnt_next + {7'h00, valid_reg[i]};
    end
  end

  // Main sequencer: receive, turnaround, transmit
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_RX;
      idx_reg      <= 5'd1;
      entry_reg    <= 5'd0;
      cc_reg       <= `SRCH_CC_OK;
      tx_cnt_reg   <= 5'd0;
      tx_pos_reg   <= 5'd0;
      turn_reg     <= 4'd0;
      cmd_reg      <= 8'h00;
      valid_reg    <= {ENTRIES{1'b0}};
      first_reg    <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_data     <= 8'h00;
      rsp_last     <= 1'b0;
      busy         <= 1'b0;
      stored_count <= 8'h00;
    end else begin
      rsp_valid    <= 1'b0;
      rsp_last     <= 1'b0;
      stored_count <= cnt_next;
      case (state_reg)
        ST_RX: begin
          busy <= 1'b0;
          if (req_valid) begin
            // Command latched on the first byte
            if (idx_reg == 5'd1) begin
              cmd_reg <= req_cmd;
            end
            if (idx_reg == `SRCH_REQ_ENTRY_BYTE) begin
              entry_reg <= req_data[4:0];
              if (req_data >= {3'b000, `SRCH_NUM_ENTRIES}) begin
                cc_reg <= `SRCH_CC_OUT_OF_RANGE;
              end
            end
            if (idx_reg != 5'd31) begin
              idx_reg <= idx_reg + 5'd1;
            end
            if (req_last) begin
              state_reg <= ST_TURN;
              busy      <= 1'b1;
              turn_reg  <= 4'd0;
            end
          end
        end
        ST_TURN: begin
          // Short pause, then decide the reply shape
          if (turn_reg >= `SRCH_TURN_CYC - 1) begin
            state_reg  <= ST_TX;
            first_reg  <= 1'b1;
            tx_pos_reg <= 5'd0;
            tx_cnt_reg <= 5'd0;
            case (cmd_reg)
              `SRCH_CMD_STORE_CFG: begin
                // Short frame leaves the valid flag unchanged, though the bytes received are already written
                if (idx_reg != `SRCH_REQ_LAST_BYTE + 5'd1) begin
                  if (cc_reg == `SRCH_CC_OK) cc_reg <= `SRCH_CC_BAD_LENGTH;
                end else if (cc_reg == `SRCH_CC_OK) begin
                  valid_reg[entry_reg] <= 1'b1;
                end
              end
              `SRCH_CMD_READ_CFG: begin
                if (idx_reg < `SRCH_REQ_ENTRY_BYTE + 5'd1) begin
                  cc_reg <= `SRCH_CC_BAD_LENGTH;
                end else if (cc_reg == `SRCH_CC_OK) begin
                  tx_cnt_reg <= `SRCH_REC_BYTES;
                end
              end
              `SRCH_CMD_SDR_INFO: begin
                // Count byte, then capability byte
                tx_cnt_reg <= 5'd2;
              end
              `SRCH_CMD_SDR_GET: begin
                entry_reg  <= 5'd0;
                tx_cnt_reg <= `SRCH_REC_BYTES;
              end
              default: begin
                cc_reg <= `SRCH_CC_INVALID_CMD;
              end
            endcase
          end else begin
            turn_reg <= turn_reg + 4'd1;
          end
        end
        ST_TX: begin
          rsp_valid <= 1'b1;
          if (first_reg) begin
            rsp_data  <= cc_reg;
            first_reg <= 1'b0;
            rsp_last  <= (tx_cnt_reg == 5'd0);
            if (tx_cnt_reg == 5'd0) begin
              // Drop busy with the final byte so no byte slips in unseen
              state_reg <= ST_RX;
              idx_reg   <= 5'd1;
              cc_reg    <= `SRCH_CC_OK;
              busy      <= 1'b0;
            end else begin
              state_reg <= ST_RD;
              rsp_valid <= 1'b1;
            end
          end else begin
            if (cmd_reg == `SRCH_CMD_SDR_INFO) begin
              // Stored count first, then the supported-command bits
              rsp_data <= (tx_pos_reg == 5'd0) ? stored_count : `SRCH_CAPS_VALUE;
            end else begin
              // Record byte read during the idle cycle before
              rsp_data <= mem_q;
            end
            tx_pos_reg <= tx_pos_reg + 5'd1;
            tx_cnt_reg <= tx_cnt_reg - 5'd1;
            rsp_last   <= (tx_cnt_reg == 5'd1);
            if (tx_cnt_reg == 5'd1) begin
              // Final byte: rearm for the next request
              state_reg <= ST_RX;
              idx_reg   <= 5'd1;
              cc_reg    <= `SRCH_CC_OK;
              busy      <= 1'b0;
            end else begin
              state_reg <= ST_RD;
            end
          end
        end
        ST_RD: begin
          // One idle cycle lets the memory read settle
          state_reg <= ST_TX;
        end
        default: begin
          state_reg <= ST_RX;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb/sensor_record_command_handler_test.sv
// Purpose: Self-checking bench for the sensor record command handler
// Assumes: Driver notes expected bytes, monitor compares in arrival order
// Notes:   Rewrites of one entry are avoided, so the count model stays simple
`include "srch_consts.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module sensor_record_command_handler_test;
  logic       clk_sys = 1'b0;
  logic       rst_n   = 1'b0;
  wire        req_valid, req_last, rsp_valid, rsp_last, busy;
  wire  [7:0] req_data, req_cmd, rsp_data, stored_count;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         seed       = 77699;
  int         cyc        = 0;
  int         count_m    = 0;
  logic [7:0] mem_m [0:17][0:12]; // Model of stored entries
  logic [8:0] exp_q [$];          // Expected {last, byte}
  logic [8:0] exp_v;
  always #12.5 clk_sys = ~clk_sys;
  srch_top #(.ENTRIES(18)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req_data(req_data), .req_last(req_last), .req_cmd(req_cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .busy(busy), .stored_count(stored_count));
  srch_host i_host (.clk_sys(clk_sys), .busy(busy), .rsp_last(rsp_last), .req_valid(req_valid),
    .req_data(req_data), .req_last(req_last), .req_cmd(req_cmd));
  function automatic logic [7:0] rnd();
    int r;
    r = $random(seed);
    return r[7:0];
  endfunction
  task automatic put(input logic last, input logic [7:0] d);
    exp_q.push_back({last, d});
  endtask
  // Send with a random slow gap between bytes
  task automatic go(input logic [7:0] cmd, input int n);
    i_host.send(cmd, n, rnd() % 3);
  endtask
  task automatic store(input int ent, input int n);
    int i;
    for (i = 0; i < 18; i++) i_host.bytes_q[i] = rnd();
    i_host.bytes_q[4] = ent[7:0];
    if (ent > 17) put(1'b1, `SRCH_CC_OUT_OF_RANGE);
    else if (n != 18) put(1'b1, `SRCH_CC_BAD_LENGTH);
    else begin
      put(1'b1, `SRCH_CC_OK);
      count_m++;
      for (i = 0; i < 13; i++) mem_m[ent][i] = i_host.bytes_q[i + 5];
    end
    go(`SRCH_CMD_STORE_CFG, n);
  endtask
  // Code then the record of one entry, as read or fetch returns it
  task automatic rec(input logic [7:0] cmd, input int ent, input int n);
    int i;
    i_host.bytes_q[4] = ent[7:0];
    put(1'b0, `SRCH_CC_OK);
    for (i = 0; i < 13; i++) put(i == 12, mem_m[ent][i]);
    go(cmd, n);
  endtask
  // Monitor takes the oldest note for every response byte
  always @(posedge clk_sys) begin
    cyc++;
    if (rst_n && rsp_valid === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
      `CHK("response byte", exp_v, {rsp_last, rsp_data})
    end
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    store(0, 18);
    store(17, 18);
    store(9, 18);
    store(18, 18);
    store(4, 10);
    rec(`SRCH_CMD_READ_CFG, 17, 5);
    rec(`SRCH_CMD_READ_CFG, 9, 5);
    put(1'b0, `SRCH_CC_OK);
    put(1'b0, count_m[7:0]);
    put(1'b1, `SRCH_CAPS_VALUE);
    go(`SRCH_CMD_SDR_INFO, 4);
    rec(`SRCH_CMD_SDR_GET, 0, 4);
    put(1'b1, `SRCH_CC_INVALID_CMD);
    go(8'h7F, 4);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("count in reset", 8'h00, stored_count)
    rst_n <= 1'b1;
    count_m = 0;
    store(3, 18);
    repeat (10) @(posedge clk_sys);
    `CHK("count after store", 8'h01, stored_count)
    `CHK("notes left", 0, exp_q.size())
    complete_run();
  end
endmodule
`default_nettype wire

// ===== tb/srch_chk.sv
// Purpose: Port checker for the sensor record command handler
// Assumes: One clock, rst_n asynchronous and active low
// Notes:   Attached to every handler instance by the bind below
`timescale 1ns/10ps
`default_nettype none
module srch_chk #(
  parameter ENTRIES = 18
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       req_valid,
  input wire logic       req_last,
  input wire logic       rsp_valid,
  input wire logic       rsp_last,
  input wire logic       busy,
  input wire logic [7:0] stored_count
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Final request byte accepted while idle
  wire take_last = req_valid && req_last && !busy;
  a_busy_rise: assert property (take_last |=> busy)
    else $error("busy did not rise after final byte");
  a_code_delay: assert property (take_last |=> !rsp_valid [*5] ##1 rsp_valid)
    else $error("completion code not 6 cycles after request");
  a_byte_spacing: assert property (rsp_valid && !rsp_last |=> !rsp_valid ##1 rsp_valid)
    else $error("response bytes not two cycles apart");
  a_last_valid: assert property (rsp_last |-> rsp_valid)
    else $error("last marker without byte strobe");
  a_last_gap: assert property (rsp_last |=> !rsp_valid)
    else $error("byte strobe right after last byte");
  a_count_max: assert property (stored_count <= ENTRIES)
    else $error("stored count above entry count");
  a_count_step: assert property ($changed(stored_count) |-> stored_count == $past(stored_count) + 8'h01)
    else $error("stored count moved by other than one");
  a_idle_quiet: assert property (!busy && !$past(busy) |-> !rsp_valid)
    else $error("response byte while idle");
  c_request: cover property (take_last);
  c_long_rsp: cover property (rsp_valid && !rsp_last ##2 rsp_valid);
  c_two_stored: cover property (stored_count == 8'h02);
endmodule
bind srch_top srch_chk #(.ENTRIES(ENTRIES)) i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .req_valid(req_valid), .req_last(req_last), .rsp_valid(rsp_valid), .rsp_last(rsp_last),
  .busy(busy), .stored_count(stored_count));
`default_nettype wire

// ===== tb/srch_host.sv
// Purpose: System manager model that sends request bytes to the handler
// Assumes: One request at a time, next one only after the final response byte
// Notes:   Idle data shows the inverse of the last byte, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module srch_host (
  input  wire logic       clk_sys,
  input  wire logic       busy,
  input  wire logic       rsp_last,
  output var  logic       req_valid,
  output var  logic [7:0] req_data,
  output var  logic       req_last,
  output var  logic [7:0] req_cmd
);
  logic [7:0] bytes_q [0:17]; // Pending request bytes
  initial begin
    req_valid = 1'b0;
    req_data  = 8'h00;
    req_last  = 1'b0;
    req_cmd   = 8'h00;
  end
  // send any request: one byte per pulse, then wait for the whole answer
  task automatic send(input logic [7:0] cmd, input int n, input int gap);
    int i;
    int w;
    for (i = 0; i < n; i++) begin
      @(posedge clk_sys);
      for (w = 0; w < 200 && busy; w++) @(posedge clk_sys);
      req_valid <= 1'b1;
      req_data  <= bytes_q[i];
      req_last  <= (i == n - 1);
      // per-device command set only, repository codes stay upstream
      req_cmd   <= cmd;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      req_last  <= 1'b0;
      req_data  <= ~bytes_q[i];
      repeat (gap) @(posedge clk_sys);
    end
    for (w = 0; w < 300 && !rsp_last; w++) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire
